// *** design/ibdiv_pkg.sv ***
// Package for the integer and BCD divider: operation codes, widths, carriers.
// Assumes a single clock domain and a sequencer that holds operands steady.
`default_nettype none
package ibdiv_pkg;
  // ----------------------------------------------------------------------
  // Widths and constants
  // ----------------------------------------------------------------------
  localparam int unsigned WORD_W   = 16;
  localparam int unsigned DWORD_W  = 32;
  localparam int unsigned DIGITS   = 4;
  localparam int unsigned DIV_STEPS = 32;
  localparam logic [15:0] MIN_WORD = 16'h8000;
  localparam logic [15:0] NEG_ONE  = 16'hffff;
  localparam logic [31:0] ZERO_DW  = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    IBDIV_OP_WORD,
    IBDIV_OP_DWORD,
    IBDIV_OP_BCD
  } ibdiv_op_t;

  typedef struct packed {
    logic        trigger;
    ibdiv_op_t   op;
    logic [31:0] dividend;
    logic [31:0] divisor;
  } ibdiv_req_t;

  typedef struct packed {
    logic        done;
    logic [31:0] quotient;
    logic [15:0] remainder_register;
    logic [15:0] remainder_high;
    logic        zero_result_flag;
    logic        overflow_flag;
  } ibdiv_rsp_t;
endpackage
`default_nettype wire

// *** design/ibdiv_bcd_conv.sv ***
// Combinational packed BCD to binary and binary to packed BCD conversion.
// Assumes inputs carry legal BCD digits; values above 9999 are not expected.
`default_nettype none
module ibdiv_bcd_conv (
  input  wire logic [15:0] bcd_i,
  output logic      [15:0] bin_o,
  input  wire logic [15:0] bin_i,
  output logic      [15:0] bcd_o
);
  // ----------------------------------------------------------------------
  // Conversion
  // ----------------------------------------------------------------------
  logic [31:0] dd;
  always_comb begin
    bin_o = 16'(bcd_i[15:12] * 16'h03e8) + 16'(bcd_i[11:8] * 16'h0064)
          + 16'(bcd_i[7:4] * 16'h000a) + 16'(bcd_i[3:0]);
    // Double dabble: shift and add three keeps each nibble a decimal digit.
    dd = {16'h0000, bin_i};
    for (int i = 0; i < 16; i++) begin
      for (int d = 0; d < 4; d++) begin
        if (dd[16+4*d +: 4] > 4'h4) begin
          dd[16+4*d +: 4] = dd[16+4*d +: 4] + 4'h3;
        end
      end
      dd = {dd[30:0], 1'b0};
    end
    bcd_o = dd[31:16];
  end
endmodule // ibdiv_bcd_conv
`default_nettype wire

// *** design/ibdiv_core.sv ***
// Divider datapath: signed word, signed double word and 4-digit BCD divide.
// Assumes the sequencer holds request fields steady while the trigger is ON.
//
// Function
// - An ON trigger divides the 16-bit dividend by the 16-bit divisor and outputs the quotient.
// - The 16-bit divide overwrites the remainder register with its remainder.
// - The 16-bit divide treats operands and results as two's-complement.
// - An ON trigger divides the 32-bit dividend by the 32-bit divisor and outputs the quotient.
// - The 32-bit divide puts its remainder in the pair, low half in the remainder register.
// - The 32-bit divide treats operands and results as signed double-width integers.
// - A zero 16-bit signed result pulses the zero-result flag for one cycle.
// - Dividing 16'h8000 by 16'hffff in 16-bit mode pulses the overflow flag for one cycle.
// - An ON trigger divides a 4-digit BCD dividend by a BCD divisor giving a BCD quotient.
// - The BCD divide writes its BCD remainder into the remainder register.
// - A zero BCD quotient pulses the zero-result flag for one cycle.
`default_nettype none
module ibdiv_core (
  input  wire logic               ref_clk_i,
  input  wire logic               rst_i,
  input  wire logic               clk_en_i,
  input  wire ibdiv_pkg::ibdiv_req_t req_i,
  output logic                    busy_o,
  output ibdiv_pkg::ibdiv_rsp_t   rsp_o
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_FINISH, ST_WAIT} ibdiv_st_t;

  typedef struct packed {
    ibdiv_st_t             st;
    ibdiv_pkg::ibdiv_op_t  op;
    logic [5:0]            cnt;
    logic [31:0]           num;
    logic [31:0]           den;
    logic [31:0]           rem;
    logic                  neg_q;
    logic                  neg_r;
    logic                  busy;
    ibdiv_pkg::ibdiv_rsp_t rsp;
  } ibdiv_state_t;

  ibdiv_state_t s_q;
  ibdiv_state_t s_d;

  logic [15:0] bcd_a_bin;
  logic [15:0] bcd_b_bin;
  logic [15:0] q_bcd;
  logic [15:0] r_bcd;

  // ----------------------------------------------------------------------
  // BCD conversion
  // ----------------------------------------------------------------------
  // Lane 0 carries the dividend and the quotient, lane 1 the divisor and
  // the remainder. Both operands convert in the cycle the trigger is taken,
  // which costs a second converter but keeps the take to a single edge.
  logic [1:0][15:0] lane_bcd_in;
  logic [1:0][15:0] lane_bin_out;
  logic [1:0][15:0] lane_bin_in;
  logic [1:0][15:0] lane_bcd_out;

  assign lane_bcd_in[0] = req_i.dividend[15:0];
  assign lane_bcd_in[1] = req_i.divisor[15:0];
  assign lane_bin_in[0] = s_q.num[15:0];
  assign lane_bin_in[1] = s_q.rem[15:0];

  for (genvar g = 0; g < 2; g++) begin : g_conv
    ibdiv_bcd_conv u_ibdiv_bcd_conv (
      .bcd_i (lane_bcd_in[g]),
      .bin_o (lane_bin_out[g]),
      .bin_i (lane_bin_in[g]),
      .bcd_o (lane_bcd_out[g])
    );
  end

  assign bcd_a_bin = lane_bin_out[0];
  assign bcd_b_bin = lane_bin_out[1];
  assign q_bcd     = lane_bcd_out[0];
  assign r_bcd     = lane_bcd_out[1];

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Magnitude of a signed double word. The most negative value maps to
  // itself, which the unsigned step logic still divides correctly.
  function automatic logic [31:0] abs32(input logic [31:0] v);
    abs32 = v[31] ? 32'(-v) : v;
  endfunction

  // Sign extension of a word to a double word.
  function automatic logic [31:0] sext16(input logic [15:0] v);
    sext16 = {{16{v[15]}}, v};
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  logic [31:0] dvd;
  logic [31:0] dvs;
  logic [32:0] trial;
  logic [31:0] qv;
  logic [31:0] rv;
  always_comb begin
    s_d = s_q;
    s_d.rsp.done = 1'b0;
    s_d.rsp.zero_result_flag = 1'b0;
    s_d.rsp.overflow_flag = 1'b0;
    dvd = ibdiv_pkg::ZERO_DW;
    dvs = ibdiv_pkg::ZERO_DW;
    trial = 33'h0_0000_0000;
    qv = ibdiv_pkg::ZERO_DW;
    rv = ibdiv_pkg::ZERO_DW;
    unique case (s_q.st)
      ST_IDLE: begin
        if (req_i.trigger) begin
          unique case (req_i.op)
            ibdiv_pkg::IBDIV_OP_WORD: begin
              dvd = sext16(req_i.dividend[15:0]);
              dvs = sext16(req_i.divisor[15:0]);
            end
            ibdiv_pkg::IBDIV_OP_DWORD: begin
              dvd = req_i.dividend;
              dvs = req_i.divisor;
            end
            default: begin
              // BCD operands are unsigned, so bit 31 stays clear.
              dvd = {16'h0000, bcd_a_bin};
              dvs = {16'h0000, bcd_b_bin};
            end
          endcase
          s_d.op = req_i.op;
          s_d.neg_q = dvd[31] ^ dvs[31];
          s_d.neg_r = dvd[31];
          s_d.num = abs32(dvd);
          s_d.den = abs32(dvs);
          s_d.rem = ibdiv_pkg::ZERO_DW;
          s_d.cnt = 6'd0;
          // Operands are taken on this edge only; busy then refuses the rest.
          s_d.busy = 1'b1;
          s_d.st = ST_RUN;
        end
      end
      ST_RUN: begin
        // One restoring step a cycle keeps the area to one subtractor.
        // A zero divisor is not flagged: every step subtracts nothing, so
        // the quotient magnitude comes out all ones and the remainder is the dividend.
        trial = {s_q.rem, s_q.num[31]} - {1'b0, s_q.den};
        if (!trial[32]) begin
          s_d.rem = trial[31:0];
          s_d.num = {s_q.num[30:0], 1'b1};
        end else begin
          s_d.rem = {s_q.rem[30:0], s_q.num[31]};
          s_d.num = {s_q.num[30:0], 1'b0};
        end
        s_d.cnt = 6'(s_q.cnt + 6'd1);
        if (s_q.cnt == 6'(ibdiv_pkg::DIV_STEPS - 1)) begin
          s_d.st = ST_FINISH;
        end
      end
      ST_FINISH: begin
        qv = s_q.neg_q ? 32'(-s_q.num) : s_q.num;
        rv = s_q.neg_r ? 32'(-s_q.rem) : s_q.rem;
        s_d.rsp.done = 1'b1;
        unique case (s_q.op)
          ibdiv_pkg::IBDIV_OP_WORD: begin
            s_d.rsp.quotient = sext16(qv[15:0]);
            s_d.rsp.remainder_register = rv[15:0];
            s_d.rsp.zero_result_flag = (qv[15:0] == 16'h0000);
            // The overflow case still delivers 16'h8000 sign-extended with
            // a zero remainder; only the flag tells it apart.
            s_d.rsp.overflow_flag =
              (s_q.neg_r && s_q.num == {16'h0000, ibdiv_pkg::MIN_WORD}
               && s_q.den == 32'h0000_0001 && !s_q.neg_q);
          end
          ibdiv_pkg::IBDIV_OP_DWORD: begin
            s_d.rsp.quotient = qv;
            s_d.rsp.remainder_register = rv[15:0];
            s_d.rsp.remainder_high = rv[31:16];
          end
          default: begin
            s_d.rsp.quotient = {16'h0000, q_bcd};
            s_d.rsp.remainder_register = r_bcd;
            s_d.rsp.zero_result_flag = (q_bcd == 16'h0000);
          end
        endcase
        s_d.st = ST_WAIT;
      end
      ST_WAIT: begin
        // Hold until the trigger drops so one ON period gives one result.
        if (!req_i.trigger) begin
          s_d.busy = 1'b0;
          s_d.st = ST_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Reset clears the last result as well, so outputs read zero after it.
  // A low clock enable freezes a divide mid-step; the result only comes late.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Both ports read flip-flops directly, so nothing combinational reaches
  // the sequencer.
  assign busy_o = s_q.busy;
  assign rsp_o  = s_q.rsp;
endmodule // ibdiv_core
`default_nettype wire

// *** tb/ibdiv_checker.sv ***
// Port checker for the divider core.
// Assumes the sequencer holds request fields until done.
`default_nettype none
module ibdiv_checker (
  input wire logic                  ref_clk_i,
  input wire logic                  rst_i,
  input wire logic                  clk_en_i,
  input wire ibdiv_pkg::ibdiv_req_t req_i,
  input wire logic                  busy_o,
  input wire ibdiv_pkg::ibdiv_rsp_t rsp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic wd;
  logic dw;
  assign wd = req_i.op == ibdiv_pkg::IBDIV_OP_WORD;
  assign dw = req_i.op == ibdiv_pkg::IBDIV_OP_DWORD;
  sequence s_take;
    clk_en_i && !busy_o && req_i.trigger;
  endsequence
  sequence s_done;
    rsp_o.done;
  endsequence
  AST_LATENCY: assert property (
    s_take |-> ##[30:36] s_done) else $error("Done late.");
  AST_BUSY: assert property (
    s_take |=> busy_o) else $error("Busy not raised.");
  AST_PULSE: assert property (
    s_done |=> !rsp_o.done) else $error("Done not a pulse.");
  AST_ZF_DONE: assert property (
    rsp_o.zero_result_flag |-> s_done) else $error("Zero flag stray.");
  AST_OF_DONE: assert property (
    rsp_o.overflow_flag |-> s_done) else $error("Overflow stray.");
  AST_OVF: assert property (s_done |-> rsp_o.overflow_flag ==
    (wd && req_i.dividend[15:0] == ibdiv_pkg::MIN_WORD
     && req_i.divisor[15:0] == ibdiv_pkg::NEG_ONE))
    else $error("Overflow flag wrong.");
  AST_ZERO: assert property (s_done |-> rsp_o.zero_result_flag ==
    (!dw && rsp_o.quotient == ibdiv_pkg::ZERO_DW))
    else $error("Zero flag wrong.");
  AST_HOLD: assert property (!rsp_o.done |->
    $stable(rsp_o.quotient) && $stable(rsp_o.remainder_register))
    else $error("Result moved without done.");
  AST_DW_ID: assert property (
    s_done ##0 (dw && req_i.divisor != 32'h0000_0000) |->
    rsp_o.quotient * req_i.divisor
    + {rsp_o.remainder_high, rsp_o.remainder_register} == req_i.dividend)
    else $error("Double word identity broken.");
endmodule // ibdiv_checker
bind ibdiv_core ibdiv_checker u_ibdiv_checker (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
  .req_i(req_i), .busy_o(busy_o), .rsp_o(rsp_o));
`default_nettype wire

// *** tb/ibdiv_seq_model.sv ***
// Sequencer model that issues one divide per trigger period.
// Assumes the core answers with a done pulse.
`default_nettype none
module ibdiv_seq_model (
  input  wire logic                  ref_clk_i,
  input  wire ibdiv_pkg::ibdiv_rsp_t rsp_i,
  output var  ibdiv_pkg::ibdiv_req_t req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Request driver
  // ----------------------------------------
  initial req_o = '0;
  task automatic run(input ibdiv_pkg::ibdiv_op_t op,
    input logic [31:0] a, b, output logic z, v, ok);
    int n;
    @(negedge ref_clk_i);
    req_o = {1'b1, op, a, b};
    ok = 1'b0;
    for (n = 0; n < 60 && !ok; n++) begin
      @(negedge ref_clk_i);
      ok = rsp_i.done === 1'b1;
    end
    z = rsp_i.zero_result_flag;
    v = rsp_i.overflow_flag;
    // Hold the request through the edge that samples done high.
    @(negedge ref_clk_i);
    // Released fields are inverted so stale operands cannot pass.
    req_o = {1'b0, op, ~a, ~b};
  endtask
endmodule // ibdiv_seq_model
`default_nettype wire

// *** tb/test_integer_bcd_divider.sv ***
// Self-checking bench for the divider core.
// Assumes the sequencer model in the same folder.
`default_nettype none
module test_integer_bcd_divider;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  logic                  ref_clk_i = 1'b0;
  logic                  rst_i     = 1'b1;
  logic                  clk_en_i  = 1'b1;
  logic                  busy;
  ibdiv_pkg::ibdiv_req_t req;
  ibdiv_pkg::ibdiv_rsp_t rsp;
  int                    error_cnt = 0;
  int                    n_checks  = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  ibdiv_core u_ibdiv_core (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .clk_en_i(clk_en_i), .req_i(req), .busy_o(busy), .rsp_o(rsp));
  ibdiv_seq_model u_ibdiv_seq_model (.ref_clk_i(ref_clk_i),
    .rsp_i(rsp), .req_o(req));
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic div(input ibdiv_pkg::ibdiv_op_t o,
    input logic [31:0] a, b, q, input logic [15:0] r, h,
    input logic ez, eo);
    logic z, v, ok;
    u_ibdiv_seq_model.run(o, a, b, z, v, ok);
    chk("done", ok, 1);
    chk("quotient", rsp.quotient, q);
    chk("remainder", rsp.remainder_register, r);
    if (o == ibdiv_pkg::IBDIV_OP_DWORD) begin
      chk("rem_high", rsp.remainder_high, h);
    end
    chk("zero", z, ez);
    chk("ovf", v, eo);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_word;
    div(ibdiv_pkg::IBDIV_OP_WORD, 36, 17, 2, 2, 0, 0, 0);
    div(ibdiv_pkg::IBDIV_OP_WORD, 32'hffdc, 17, 32'hfffffffe,
      16'hfffe, 0, 0, 0);
    div(ibdiv_pkg::IBDIV_OP_WORD, 5, 9, 0, 5, 0, 1, 0);
  endtask
  task automatic t_ovf;
    div(ibdiv_pkg::IBDIV_OP_WORD, 32'h8000, 32'hffff, 32'hffff8000,
      0, 0, 0, 1);
  endtask
  task automatic t_bcd;
    div(ibdiv_pkg::IBDIV_OP_BCD, 32'h37, 32'h15, 2, 7, 0, 0, 0);
    div(ibdiv_pkg::IBDIV_OP_BCD, 32'h12, 32'h345, 0, 16'h12,
      0, 1, 0);
  endtask
  task automatic t_dword;
    div(ibdiv_pkg::IBDIV_OP_DWORD, 5, 9, 0, 5, 0, 0, 0);
    div(ibdiv_pkg::IBDIV_OP_DWORD, 32'h01020080, 32'h00090004, 28,
      16'h0010, 16'h0006, 0, 0);
    div(ibdiv_pkg::IBDIV_OP_DWORD, 32'hfefdff80, 32'h00090004,
      32'hffffffe4, 16'hfff0, 16'hfff9, 0, 0);
  endtask
  task automatic t_freeze;
    int n;
    n = 0;
    fork
      div(ibdiv_pkg::IBDIV_OP_WORD, 36, 17, 2, 2, 0, 0, 0);
      begin
        repeat (8) @(negedge ref_clk_i);
        clk_en_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        clk_en_i = 1'b1;
      end
      while (rsp.done !== 1'b1) begin
        @(negedge ref_clk_i);
        n++;
      end
    join
    chk("freeze_cycles", n, 37);
  endtask
  task automatic t_idle;
    repeat (10) @(negedge ref_clk_i);
    chk("idle_q", rsp.quotient, 32'hffffffe4);
    chk("idle_r", rsp.remainder_register, 16'hfff0);
    chk("idle_z", rsp.zero_result_flag, 0);
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (4) @(negedge ref_clk_i);
    rst_i = 1'b0;
    t_word();
    t_ovf();
    t_bcd();
    t_freeze();
    t_dword();
    t_idle();
    wrap_up();
  end
endmodule // test_integer_bcd_divider
`default_nettype wire
